/* File: vtp_pkg.sv */
// constants and carrier types for the video test pattern configuration block
// How it works
// - scale bit 0 gives one-pixel checkers; 1 gives eight-by-eight checkers.
// - custom-checker bit picks custom colour and black, else white and black.
// - depth bit 0 gives 256 ramp levels, 1 gives 64 ramp levels.
// - reduced depth drives pattern data only on six top bits per colour.
// - internal timing picks divided clock at 0, external pixel clock at 1.
// - clock-source bit is ignored while external timing is selected.
// - external timing follows incoming pixel clock, enable and both syncs.
// - internal timing builds frames from the programmed timing registers.
// - invert bit outputs the inverted colour of every pattern pixel.
// - auto-scroll steps to the next pattern after frame-time frames.
// - the index register picks which indirect register data accesses reach.
// - a value-register write lands in the indirect register at the index.
// - a value-register read returns the indirect register at the index.
// - pattern video only while enable is 1; enable resets to 0.
// - select code 1110 outputs the custom colour, or its inversion.
package vtp_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] PATTERN_CONTROL_ADDR = 8'h64;
	localparam logic [7:0] PATTERN_CONFIG_ADDR = 8'h65;
	localparam logic [7:0] PATTERN_INDIRECT_INDEX_ADDR = 8'h66;
	localparam logic [7:0] PATTERN_INDIRECT_VALUE_ADDR = 8'h67;
	localparam logic [7:0] PATTERN_CONTROL_RESET = 8'h10;
	localparam logic [7:0] PATTERN_CONFIG_RESET = 8'h00;
	localparam logic [7:0] PATTERN_INDEX_RESET = 8'h00;
	localparam logic [7:0] INDIRECT_RESET = 8'h00;
	// ==========================================
	// indirect map
	localparam int INDIRECT_DEPTH = 17;
	localparam logic [7:0] IDX_CUSTOM_RED = 8'h00;
	localparam logic [7:0] IDX_CUSTOM_GREEN = 8'h01;
	localparam logic [7:0] IDX_CUSTOM_BLUE = 8'h02;
	localparam logic [7:0] IDX_FRAME_TIME = 8'h03;
	localparam logic [7:0] IDX_HTOTAL_LO = 8'h04;
	localparam logic [7:0] IDX_HTOTAL_HI = 8'h05;
	localparam logic [7:0] IDX_VTOTAL_LO = 8'h06;
	localparam logic [7:0] IDX_VTOTAL_HI = 8'h07;
	localparam logic [7:0] IDX_HACTIVE_LO = 8'h08;
	localparam logic [7:0] IDX_HACTIVE_HI = 8'h09;
	localparam logic [7:0] IDX_VACTIVE_LO = 8'h0a;
	localparam logic [7:0] IDX_VACTIVE_HI = 8'h0b;
	localparam logic [7:0] IDX_HSYNC_WIDTH = 8'h0c;
	localparam logic [7:0] IDX_VSYNC_WIDTH = 8'h0d;
	localparam logic [7:0] IDX_HBACK_PORCH = 8'h0e;
	localparam logic [7:0] IDX_VBACK_PORCH = 8'h0f;
	localparam logic [7:0] IDX_SYNC_CONFIG = 8'h10;
	// ==========================================
	// pattern codes and timing
	localparam logic [3:0] SEL_CHECKER = 4'h0;
	localparam logic [3:0] SEL_CUSTOM = 4'he;
	localparam logic [3:0] SEL_COMMON_VOLTAGE = 4'hf;
	localparam logic [3:0] SCROLL_RESET = 4'h0;
	localparam logic [7:0] REDUCED_MASK = 8'hfc;
	localparam int CHECK_FINE_BIT = 0;
	localparam int CHECK_COARSE_BIT = 3;
	localparam logic [3:0] INTERNAL_DIVIDE = 4'h2;
	localparam logic [3:0] DIVIDE_RESET = 4'h0;

	typedef struct packed {
		logic reserved;
		logic checkerScale;
		logic customChecker;
		logic reducedDepthSelect;
		logic externalClock;
		logic patternTimingSourceSelect;
		logic colourInvert;
		logic autoScroll;
	} vtp_config_t;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
		logic de;
		logic hs;
		logic vs;
	} vtp_pixel_t;

	localparam vtp_pixel_t PIXEL_RESET = '0;
endpackage

/* File: vtp_generator.sv */
// pattern generator configuration, indirect registers and pixel path
`timescale 1ns/1ps
module vtp_generator
	import vtp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWriteStrobe,
	input wire logic regReadStrobe,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	// incoming video pins
	input wire logic vidPclk,
	input wire vtp_pixel_t vidIn,
	// video toward the display output
	output vtp_pixel_t vidOut,
	output logic vidOutStrobe
);
	// ==========================================
	// registers and indirect store
	logic [7:0] controlReg;
	logic [7:0] configReg;
	logic [7:0] indexReg;
	logic [7:0] indirectMem [INDIRECT_DEPTH];
	logic indexHit;
	logic writeValue;
	logic [7:0] indirectRead;
	logic [7:0] readNext;

	assign indexHit = indexReg < 8'(INDIRECT_DEPTH);
	assign writeValue = regWriteStrobe && regAddr == PATTERN_INDIRECT_VALUE_ADDR;
	assign indirectRead = indexHit ? indirectMem[indexReg[4:0]] : 8'h00;
	assign readNext = regAddr == PATTERN_CONTROL_ADDR ? controlReg :
		regAddr == PATTERN_CONFIG_ADDR ? {1'b0, configReg[6:0]} :
		regAddr == PATTERN_INDIRECT_INDEX_ADDR ? indexReg :
		regAddr == PATTERN_INDIRECT_VALUE_ADDR ? indirectRead : 8'h00;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			controlReg <= PATTERN_CONTROL_RESET;
			configReg <= PATTERN_CONFIG_RESET;
			indexReg <= PATTERN_INDEX_RESET;
			regReadData <= 8'h00;
		end else begin
			if (regWriteStrobe && regAddr == PATTERN_CONTROL_ADDR)
				controlReg <= regWriteData;
			if (regWriteStrobe && regAddr == PATTERN_CONFIG_ADDR)
				configReg <= regWriteData;
			if (regWriteStrobe && regAddr == PATTERN_INDIRECT_INDEX_ADDR)
				indexReg <= regWriteData;
			if (regReadStrobe)
				regReadData <= readNext;
		end
	end

	generate
		for (genvar i = 0; i < INDIRECT_DEPTH; i++) begin : gIndirect
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn)
					indirectMem[i] <= INDIRECT_RESET;
				else if (writeValue && indexReg == 8'(i))
					indirectMem[i] <= regWriteData;
			end
		end
	endgenerate

	// ==========================================
	// pin synchronisers and clock choice
	logic [2:0] pclkSync;
	vtp_pixel_t vidMeta;
	vtp_pixel_t vidSync;
	logic vsLast;
	logic [3:0] divCnt;
	logic divTick;
	logic extRise;
	logic pixTick;
	vtp_config_t activeCfg;
	logic [7:0] activeCtl;
	logic genOn;

	assign extRise = pclkSync[1] && !pclkSync[2];
	assign divTick = divCnt == INTERNAL_DIVIDE - 4'h1;
	assign genOn = activeCtl[0];
	// clock source only counts under internal timing
	assign pixTick = (activeCfg.patternTimingSourceSelect && !activeCfg.externalClock) ?
		divTick : extRise;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pclkSync <= 3'h0;
			vidMeta <= PIXEL_RESET;
			vidSync <= PIXEL_RESET;
			divCnt <= DIVIDE_RESET;
		end else begin
			pclkSync <= {pclkSync[1:0], vidPclk};
			vidMeta <= vidIn;
			vidSync <= vidMeta;
			divCnt <= divTick ? DIVIDE_RESET : divCnt + 4'h1;
		end
	end

	// ==========================================
	// frame timing
	logic [11:0] hTotal, vTotal, hActive, vActive, hStart, vStart;
	logic [11:0] hCnt, vCnt, xExt, yExt, xPos, yPos;
	logic hWrap, vWrap, hIn, vIn, frameStart, loadShadow, deLast;
	logic [1:0] syncPol;

	assign hTotal = {indirectMem[IDX_HTOTAL_HI[4:0]][3:0], indirectMem[IDX_HTOTAL_LO[4:0]]};
	assign vTotal = {indirectMem[IDX_VTOTAL_HI[4:0]][3:0], indirectMem[IDX_VTOTAL_LO[4:0]]};
	assign hActive = {indirectMem[IDX_HACTIVE_HI[4:0]][3:0], indirectMem[IDX_HACTIVE_LO[4:0]]};
	assign vActive = {indirectMem[IDX_VACTIVE_HI[4:0]][3:0], indirectMem[IDX_VACTIVE_LO[4:0]]};
	assign hStart = 12'(indirectMem[IDX_HSYNC_WIDTH[4:0]]) + 12'(indirectMem[IDX_HBACK_PORCH[4:0]]);
	assign vStart = 12'(indirectMem[IDX_VSYNC_WIDTH[4:0]]) + 12'(indirectMem[IDX_VBACK_PORCH[4:0]]);
	assign syncPol = indirectMem[IDX_SYNC_CONFIG[4:0]][1:0];
	// programmed totals, actives, syncs and porches
	assign hWrap = {1'b0, hCnt} + 13'h1 >= {1'b0, hTotal};
	assign vWrap = {1'b0, vCnt} + 13'h1 >= {1'b0, vTotal};
	assign hIn = hCnt >= hStart && {1'b0, hCnt} < {1'b0, hStart} + {1'b0, hActive};
	assign vIn = vCnt >= vStart && {1'b0, vCnt} < {1'b0, vStart} + {1'b0, vActive};
	// external frames start at the rising vertical sync
	assign frameStart = pixTick && (activeCfg.patternTimingSourceSelect ?
		(hWrap && vWrap) : (vidSync.vs && !vsLast));
	// settings only swap at a frame edge while running
	assign loadShadow = frameStart || !genOn;
	assign xPos = activeCfg.patternTimingSourceSelect ? hCnt - hStart : xExt;
	assign yPos = activeCfg.patternTimingSourceSelect ? vCnt - vStart : yExt;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hCnt <= 12'h000;
			vCnt <= 12'h000;
			xExt <= 12'h000;
			yExt <= 12'h000;
			vsLast <= 1'b0;
			deLast <= 1'b0;
			activeCfg <= vtp_config_t'(PATTERN_CONFIG_RESET);
			activeCtl <= PATTERN_CONTROL_RESET;
		end else begin
			if (loadShadow) begin
				activeCfg <= vtp_config_t'(configReg);
				activeCtl <= controlReg;
			end
			if (pixTick) begin
				hCnt <= hWrap ? 12'h000 : hCnt + 12'h001;
				if (hWrap)
					vCnt <= vWrap ? 12'h000 : vCnt + 12'h001;
				vsLast <= vidSync.vs;
				deLast <= vidSync.de;
				xExt <= vidSync.de ? xExt + 12'h001 : 12'h000;
				if (vidSync.vs && !vsLast)
					yExt <= 12'h000;
				else if (deLast && !vidSync.de)
					yExt <= yExt + 12'h001;
			end
		end
	end

	// ==========================================
	// auto scroll
	logic [3:0] scrollSel;
	logic [7:0] frameCnt;
	logic [3:0] curSel;
	logic scrollStep;

	assign scrollStep = frameCnt + 8'h01 >= indirectMem[IDX_FRAME_TIME[4:0]];
	assign curSel = activeCfg.autoScroll ? scrollSel : activeCtl[7:4];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scrollSel <= SCROLL_RESET;
			frameCnt <= 8'h00;
		end else if (frameStart && activeCfg.autoScroll) begin
			frameCnt <= scrollStep ? 8'h00 : frameCnt + 8'h01;
			if (scrollStep)
				scrollSel <= scrollSel + 4'h1;
		end
	end

	// ==========================================
	// pattern colour
	logic checkerCell;
	logic [7:0] ramp, level, custR, custG, custB;
	logic [2:0] bandMask;
	logic [23:0] rawColour, outColour;
	vtp_pixel_t genPixel;

	assign custR = indirectMem[IDX_CUSTOM_RED[4:0]];
	assign custG = indirectMem[IDX_CUSTOM_GREEN[4:0]];
	assign custB = indirectMem[IDX_CUSTOM_BLUE[4:0]];
	assign checkerCell = activeCfg.checkerScale ?
		(xPos[CHECK_COARSE_BIT] ^ yPos[CHECK_COARSE_BIT]) :
		(xPos[CHECK_FINE_BIT] ^ yPos[CHECK_FINE_BIT]);
	assign ramp = curSel < 4'ha ? xPos[7:0] : yPos[7:0];
	// ramps lose two steps bits in reduced depth
	assign level = activeCfg.reducedDepthSelect ? (ramp & REDUCED_MASK) : ramp;
	assign bandMask = (curSel == 4'h6 || curSel == 4'ha) ? 3'h7 :
		(curSel == 4'h7 || curSel == 4'hb) ? 3'h4 :
		(curSel == 4'h8 || curSel == 4'hc) ? 3'h2 : 3'h1;

	always_comb begin
		case (curSel)
			SEL_CHECKER: rawColour = !checkerCell ? 24'h000000 :
				activeCfg.customChecker ? {custR, custG, custB} : 24'hffffff;
			4'h1: rawColour = 24'hffffff;
			4'h2: rawColour = 24'h000000;
			4'h3: rawColour = 24'hff0000;
			4'h4: rawColour = 24'h00ff00;
			4'h5: rawColour = 24'h0000ff;
			SEL_CUSTOM: rawColour = {custR, custG, custB};
			SEL_COMMON_VOLTAGE: rawColour = checkerCell ? 24'hffff00 : 24'h0000ff;
			default: rawColour = {bandMask[2] ? level : 8'h00,
				bandMask[1] ? level : 8'h00, bandMask[0] ? level : 8'h00};
		endcase
	end

	// invert, then keep only top six bits in reduced depth
	assign outColour = (activeCfg.colourInvert ? ~rawColour : rawColour) &
		(activeCfg.reducedDepthSelect ? {3{REDUCED_MASK}} : 24'hffffff);

	always_comb begin
		genPixel = vidSync;
		genPixel.red = outColour[23:16];
		genPixel.green = outColour[15:8];
		genPixel.blue = outColour[7:0];
		if (activeCfg.patternTimingSourceSelect) begin
			genPixel.de = hIn && vIn;
			genPixel.hs = (hCnt < 12'(indirectMem[IDX_HSYNC_WIDTH[4:0]])) ^ !syncPol[0];
			genPixel.vs = (vCnt < 12'(indirectMem[IDX_VSYNC_WIDTH[4:0]])) ^ !syncPol[1];
		end
	end

	// pattern replaces video only while enabled
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vidOut <= PIXEL_RESET;
			vidOutStrobe <= 1'b0;
		end else begin
			vidOutStrobe <= pixTick;
			if (pixTick)
				vidOut <= genOn ? genPixel : vidSync;
		end
	end

	// ==========================================
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_reduced_low_bits: assert property ($past(pixTick && genOn &&
		activeCfg.reducedDepthSelect) |-> vidOut.red[1:0] == 2'h0 && vidOut.blue[1:0] == 2'h0)
		else $error("reduced depth drove low colour bits");
	a_disabled_pass: assert property ($past(pixTick && !genOn) |-> vidOut == $past(vidSync))
		else $error("disabled generator altered video");
	a_custom_colour: assert property ($past(pixTick && genOn && curSel == SEL_CUSTOM &&
		!activeCfg.colourInvert && !activeCfg.reducedDepthSelect) |-> vidOut.red == $past(custR))
		else $error("custom colour not output");
	a_invert_custom: assert property ($past(pixTick && genOn && curSel == SEL_CUSTOM &&
		activeCfg.colourInvert && !activeCfg.reducedDepthSelect) |-> vidOut.green == ~$past(custG))
		else $error("inverted colour not output");
	a_value_read: assert property (regReadStrobe &&
		regAddr == PATTERN_INDIRECT_VALUE_ADDR && indexHit
		|=> regReadData == $past(indirectMem[indexReg[4:0]]))
		else $error("indirect read returned wrong byte");
	a_value_write: assert property (writeValue && indexReg == IDX_FRAME_TIME
		|=> indirectMem[IDX_FRAME_TIME[4:0]] == $past(regWriteData))
		else $error("indirect write lost");
	a_shadow_frame: assert property (!$stable(activeCfg) |-> $past(loadShadow))
		else $error("configuration changed inside a frame");
	a_clock_ignored: assert property (!activeCfg.patternTimingSourceSelect |-> pixTick == extRise)
		else $error("clock source used under external timing");
	a_scroll_hold: assert property (!$stable(scrollSel) |-> $past(activeCfg.autoScroll && frameStart))
		else $error("pattern advanced without auto scroll");
	a_checker_scale: assert property (activeCfg.checkerScale
		|-> checkerCell == (xPos[3] ^ yPos[3]))
		else $error("checker square size wrong");
	a_external_de: assert property ($past(pixTick && genOn &&
		!activeCfg.patternTimingSourceSelect) |-> vidOut.de == $past(vidSync.de))
		else $error("external enable not followed");
endmodule

/* File: vtp_panel_model.sv */
// display panel model that latches generated pixels
`timescale 1ns/1ps
module vtp_panel_model
	import vtp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// video from the generator
	input wire vtp_pixel_t vidOut,
	input wire logic vidOutStrobe,
	// captured state
	output vtp_pixel_t lastPixel,
	output int strobeCount
);
	// ==========================================
	// capture
	// one pixel per strobe; the count lets the bench measure pixel rate
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lastPixel <= PIXEL_RESET;
			strobeCount <= 0;
		end else if (vidOutStrobe) begin
			lastPixel <= vidOut;
			strobeCount <= strobeCount + 1;
		end
	end
endmodule

/* File: video_test_pattern_config_test.sv */
// self-checking bench for the pattern generator configuration block
`timescale 1ns/1ps
module video_test_pattern_config_test;
	import vtp_pkg::*;
	logic core_clk, rstn, regWriteStrobe, regReadStrobe, vidPclk, vidOutStrobe;
	logic [7:0] regAddr, regWriteData, regReadData, rd;
	vtp_pixel_t vidIn, vidOut, lastPixel;
	int strobeCount, fails, compares, cycles, n0;
	logic [23:0] c [0:8];
	logic [23:0] custom = 24'h3c5a96;
	logic [7:0] tbl [0:11] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00,
		8'h01, 8'h01, 8'h01, 8'h01};
	vtp_generator u_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
		.regWriteStrobe(regWriteStrobe), .regReadStrobe(regReadStrobe),
		.regWriteData(regWriteData), .regReadData(regReadData), .vidPclk(vidPclk),
		.vidIn(vidIn), .vidOut(vidOut), .vidOutStrobe(vidOutStrobe));
	vtp_panel_model u_panel (.core_clk(core_clk), .rstn(rstn), .vidOut(vidOut),
		.vidOutStrobe(vidOutStrobe), .lastPixel(lastPixel), .strobeCount(strobeCount));
	// ==========================================
	// clock and watchdog
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	// ==========================================
	// helpers
	task automatic report_and_stop();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp24(string what, logic [23:0] exp, logic [23:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmpCount(string what, int exp, int got);
		compares++;
		if (got != exp) begin
			fails++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	function automatic logic [23:0] seen();
		return {lastPixel.red, lastPixel.green, lastPixel.blue};
	endfunction
	task automatic regWrite(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWriteData <= d;
		regWriteStrobe <= 1'h1;
		@(posedge core_clk);
		regWriteStrobe <= 1'h0;
	endtask
	task automatic regRead(logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regReadStrobe <= 1'h1;
		@(posedge core_clk);
		regReadStrobe <= 1'h0;
		#1 d = regReadData;
	endtask
	task automatic setIndirect(logic [7:0] idx, logic [7:0] val);
		regWrite(PATTERN_INDIRECT_INDEX_ADDR, idx);
		regWrite(PATTERN_INDIRECT_VALUE_ADDR, val);
	endtask
	// pixel clock high four core cycles, then low at least four (five between back-to-back pixels), well under core_clk/2
	task automatic pixel(logic [23:0] col, logic de, logic vs);
		@(posedge core_clk);
		vidIn <= {col, de, 1'h0, vs};
		vidPclk <= 1'h1;
		repeat (4) @(posedge core_clk);
		vidPclk <= 1'h0;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic frame();
		pixel(24'h000000, 1'h0, 1'h1);
		pixel(24'h000000, 1'h0, 1'h0);
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs();
		regRead(PATTERN_CONTROL_ADDR, rd);
		cmp8("control reset", 8'h10, rd);
		regRead(PATTERN_CONFIG_ADDR, rd);
		cmp8("config reset", 8'h00, rd);
		regRead(PATTERN_INDIRECT_INDEX_ADDR, rd);
		cmp8("index reset", 8'h00, rd);
		regRead(PATTERN_INDIRECT_VALUE_ADDR, rd);
		cmp8("value reset", 8'h00, rd);
		regRead(8'h68, rd);
		cmp8("unmapped read", 8'h00, rd);
		regWrite(PATTERN_CONFIG_ADDR, 8'hff);
		regRead(PATTERN_CONFIG_ADDR, rd);
		cmp8("config reserved bit", 8'h7f, rd);
		regWrite(PATTERN_CONFIG_ADDR, 8'h00);
	endtask
	task automatic t_indirect();
		for (int i = 0; i <= 16; i++) setIndirect(i[7:0], i[7:0] ^ 8'h5a);
		for (int i = 16; i >= 0; i--) begin
			regWrite(PATTERN_INDIRECT_INDEX_ADDR, i[7:0]);
			regRead(PATTERN_INDIRECT_VALUE_ADDR, rd);
			cmp8("indirect readback", i[7:0] ^ 8'h5a, rd);
		end
		setIndirect(8'h11, 8'h77);
		regRead(PATTERN_INDIRECT_VALUE_ADDR, rd);
		cmp8("index beyond map", 8'h00, rd);
	endtask
	task automatic t_custom();
		pixel(24'h123456, 1'h1, 1'h0);
		cmp24("passthrough", 24'h123456, seen());
		setIndirect(IDX_CUSTOM_RED, custom[23:16]);
		setIndirect(IDX_CUSTOM_GREEN, custom[15:8]);
		setIndirect(IDX_CUSTOM_BLUE, custom[7:0]);
		regWrite(PATTERN_CONTROL_ADDR, 8'he1);
		// external clock bit set under external timing must change nothing
		regWrite(PATTERN_CONFIG_ADDR, 8'h08);
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("custom colour", custom, seen());
		regWrite(PATTERN_CONFIG_ADDR, 8'h0a);
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("held until frame", custom, seen());
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("inverted", ~custom, seen());
		regWrite(PATTERN_CONFIG_ADDR, 8'h1a);
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("reduced depth", ~custom & 24'hfcfcfc, seen());
	endtask
	task automatic t_checker();
		logic [7:0] cfgs [0:2] = '{8'h00, 8'h40, 8'h60};
		regWrite(PATTERN_CONTROL_ADDR, 8'h01);
		for (int k = 0; k < 3; k++) begin
			regWrite(PATTERN_CONFIG_ADDR, cfgs[k]);
			frame();
			for (int i = 0; i < 9; i++) begin
				pixel(24'h000000, 1'h1, 1'h0);
				c[i] = seen();
			end
			if (k == 0) begin
				cmp24("fine neighbour", ~c[0], c[1]);
				cmp24("white and black", 24'hffffff, c[0] | c[1]);
			end else begin
				cmp24("coarse square", c[0], c[7]);
			end
			if (k == 1) cmp24("coarse edge", ~c[0], c[8]);
			if (k == 2) begin
				cmp24("custom checker", custom, c[0] | c[8]);
				cmp24("custom black", 24'h000000, c[0] & c[8]);
			end
		end
	endtask
	// horizontal ramp: level follows the column, two low bits dropped in reduced depth
	task automatic t_ramp();
		regWrite(PATTERN_CONTROL_ADDR, 8'h61);
		regWrite(PATTERN_CONFIG_ADDR, 8'h00);
		for (int k = 0; k < 2; k++) begin
			frame();
			for (int i = 0; i < 4; i++) begin
				pixel(24'h000000, 1'h1, 1'h0);
				c[i] = seen();
			end
			if (k == 0) begin
				cmp24("ramp level one", 24'h010101, c[1]);
				cmp24("ramp level three", 24'h030303, c[3]);
			end else begin
				cmp24("reduced ramp level three", 24'h000000, c[3]);
			end
			regWrite(PATTERN_CONFIG_ADDR, 8'h10);
		end
	endtask
	// scroll starts from code 0, so codes 1 and 2 follow frame by frame, then 3 after two frames
	task automatic t_scroll();
		setIndirect(IDX_FRAME_TIME, 8'h01);
		regWrite(PATTERN_CONFIG_ADDR, 8'h01);
		frame();
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("scroll to white", 24'hffffff, seen());
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("scroll to black", 24'h000000, seen());
		setIndirect(IDX_FRAME_TIME, 8'h02);
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("held for frame time", 24'h000000, seen());
		frame();
		pixel(24'h000000, 1'h1, 1'h0);
		cmp24("scroll to red", 24'hff0000, seen());
	endtask
	task automatic t_internal();
		for (int i = 0; i < 12; i++) setIndirect(IDX_HTOTAL_LO + i[7:0], tbl[i]);
		regWrite(PATTERN_CONFIG_ADDR, 8'h04);
		frame();
		repeat (100) @(posedge core_clk);
		#1 n0 = strobeCount;
		repeat (40) @(posedge core_clk);
		#1 cmpCount("divided clock pixels", 20, strobeCount - n0);
		regWrite(PATTERN_CONFIG_ADDR, 8'h0c);
		repeat (100) @(posedge core_clk);
		#1 n0 = strobeCount;
		repeat (40) @(posedge core_clk);
		#1 cmpCount("stopped pixel clock", 0, strobeCount - n0);
		n0 = strobeCount;
		for (int i = 0; i < 5; i++) pixel(24'h000000, 1'h0, 1'h0);
		cmpCount("external clock pixels", 5, strobeCount - n0);
	endtask
	// ==========================================
	// main sequence
	initial begin
		rstn = 1'h0;
		regAddr = 8'h00;
		regWriteData = 8'h00;
		regWriteStrobe = 1'h0;
		regReadStrobe = 1'h0;
		vidPclk = 1'h0;
		vidIn = '0;
		fails = 0;
		compares = 0;
		cycles = 0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'h1;
		t_regs();
		t_indirect();
		t_custom();
		t_checker();
		t_ramp();
		t_scroll();
		t_internal();
		report_and_stop();
	end
endmodule
